// *** rtl/acem_consts.svh ***
// Constants for the AXI channel event monitor
// Summary of operation
// - Read command event opens in first cycle read address valid is high.
// - Read command event closes when read address valid and ready high.
// - Read address channel idle while no command event is in progress.
// - Non-last read beat: read valid and ready high, last low.
// - Last read beat: read valid, ready and last all high.
// - Read data channel reports idle when no beat of either kind occurs.
// - Write command event opens in first cycle write address valid is high.
// - Write command event closes when write address valid and ready high.
// - Write address channel idle while no command event is in progress.
// - Non-last write beat: valid and ready high now, one low last cycle.
// - Last write beat: write valid, ready and last all high.
// - Write data channel reports idle when no beat of either kind occurs.
// - Response event when response valid and ready high, else idle.
// - Each completed transaction gives address, ID, start, end, duration.
// - Read address record holds command fields and outstanding read count.
// - Write data record holds only valid, ready, last, data and strobes.
// - Read transaction runs from read command start to last read beat.
// - Write transaction runs from write command start to write response.
// - Events join into one transaction only with matching IDs.
// - Overflow when one ID exceeds its counter or IDs exceed counters.
`ifndef ACEM_CONSTS_SVH
`define ACEM_CONSTS_SVH
`define ACEM_ID_W 4
`define ACEM_ADDR_W 32
`define ACEM_DATA_W 32
`define ACEM_TIME_W 32
`define ACEM_LOCK_W 1
`define ACEM_NUM_SLOTS 4
`define ACEM_DEPTH 4
`endif

// *** rtl/acem_pkg.sv ***
// Types for the AXI channel event monitor
package acem_pkg;
	// Address channel state, one-hot
	typedef enum logic [1:0] {
		ACEM_AEV_IDLE = 2'b01,
		ACEM_AEV_CMD = 2'b10
	} acem_addr_ev_e;
	// Data channel event, one-hot
	typedef enum logic [2:0] {
		ACEM_DEV_IDLE = 3'b001,
		ACEM_DEV_BEAT = 3'b010,
		ACEM_DEV_LAST = 3'b100
	} acem_data_ev_e;
	// Response channel event, one-hot
	typedef enum logic [1:0] {
		ACEM_BEV_IDLE = 2'b01,
		ACEM_BEV_RESP = 2'b10
	} acem_resp_ev_e;
endpackage

// *** rtl/acem_txn_tracker.sv ***
// Per-ID outstanding transaction tracker
`timescale 1ns/1ps
module acem_txn_tracker #(
	parameter int ID_W = 4,
	parameter int ADDR_W = 32,
	parameter int TIME_W = 32,
	parameter int NUM_SLOTS = 4,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic open_valid,
	input wire logic [ID_W-1:0] open_id,
	input wire logic [ADDR_W-1:0] open_addr,
	input wire logic [TIME_W-1:0] open_time,
	input wire logic close_valid,
	input wire logic [ID_W-1:0] close_id,
	input wire logic [TIME_W-1:0] close_time,
	output logic done_valid_reg,
	output logic [ID_W-1:0] done_id_reg,
	output logic [ADDR_W-1:0] done_addr_reg,
	output logic [TIME_W-1:0] done_start_reg,
	output logic [TIME_W-1:0] done_end_reg,
	output logic [TIME_W-1:0] done_dur_reg,
	output logic [15:0] outstanding_reg,
	output logic overflow_reg
);
	import acem_pkg::*;
	localparam int SLOT_W = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1;
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

	// Each slot is an in-order queue for one ID; AXI keeps same-ID order
	logic [ID_W-1:0] id_reg [NUM_SLOTS];
	logic [CNT_W-1:0] cnt_reg [NUM_SLOTS];
	logic [PTR_W-1:0] wr_reg [NUM_SLOTS];
	logic [PTR_W-1:0] rd_reg [NUM_SLOTS];
	logic [ADDR_W-1:0] addr_mem [NUM_SLOTS][DEPTH];
	logic [TIME_W-1:0] time_mem [NUM_SLOTS][DEPTH];
	logic open_hit, free_found, close_hit, push, pop;
	logic [SLOT_W-1:0] open_slot, free_slot, close_slot, tgt_slot;
	logic [15:0] total;

	// Slot lookup by ID; lowest index wins
	always_comb begin
		open_hit = 1'b0;
		free_found = 1'b0;
		close_hit = 1'b0;
		open_slot = '0;
		free_slot = '0;
		close_slot = '0;
		total = '0;
		for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
			total = total + 16'(cnt_reg[i]);
			if (cnt_reg[i] != '0 && id_reg[i] == open_id) begin
				open_hit = 1'b1;
				open_slot = SLOT_W'(i);
			end
			if (cnt_reg[i] == '0) begin
				free_found = 1'b1;
				free_slot = SLOT_W'(i);
			end
			if (cnt_reg[i] != '0 && id_reg[i] == close_id) begin
				close_hit = 1'b1;
				close_slot = SLOT_W'(i);
			end
		end
		tgt_slot = open_hit ? open_slot : free_slot;
		push = open_valid && (open_hit ? cnt_reg[open_slot] != FULL :
			free_found);
		pop = close_valid && close_hit;
	end

	// Queue bookkeeping per slot
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				id_reg[i] <= '0;
				cnt_reg[i] <= '0;
				wr_reg[i] <= '0;
				rd_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				if (push && tgt_slot == SLOT_W'(i)) begin
					id_reg[i] <= open_id;
					wr_reg[i] <= wr_reg[i] + PTR_W'(1);
				end
				if (pop && close_slot == SLOT_W'(i))
					rd_reg[i] <= rd_reg[i] + PTR_W'(1);
				cnt_reg[i] <= cnt_reg[i]
					+ CNT_W'(push && tgt_slot == SLOT_W'(i))
					- CNT_W'(pop && close_slot == SLOT_W'(i));
			end
		end
	end

	// Entry storage needs no reset
	always_ff @(posedge clk) begin
		if (push) begin
			addr_mem[tgt_slot][wr_reg[tgt_slot]] <= open_addr;
			time_mem[tgt_slot][wr_reg[tgt_slot]] <= open_time;
		end
	end

	// Completed transaction report
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_valid_reg <= 1'b0;
			done_id_reg <= '0;
			done_addr_reg <= '0;
			done_start_reg <= '0;
			done_end_reg <= '0;
			done_dur_reg <= '0;
		end else begin
			done_valid_reg <= pop;
			if (pop) begin
				done_id_reg <= close_id;
				done_addr_reg <= addr_mem[close_slot][rd_reg[close_slot]];
				done_start_reg <= time_mem[close_slot][rd_reg[close_slot]];
				done_end_reg <= close_time;
				done_dur_reg <= close_time
					- time_mem[close_slot][rd_reg[close_slot]];
			end
		end
	end

	// Sticky overflow; count of tracked outstanding transactions
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overflow_reg <= 1'b0;
			outstanding_reg <= '0;
		end else begin
			if (open_valid && !push)
				overflow_reg <= 1'b1;
			outstanding_reg <= total;
		end
	end
endmodule // acem_txn_tracker

// *** rtl/acem_monitor.sv ***
// Passive AXI channel event monitor, top level
`timescale 1ns/1ps
`include "acem_consts.svh"
module acem_monitor #(
	parameter int ID_W = `ACEM_ID_W,
	parameter int ADDR_W = `ACEM_ADDR_W,
	parameter int DATA_W = `ACEM_DATA_W,
	parameter int TIME_W = `ACEM_TIME_W,
	parameter int LOCK_W = `ACEM_LOCK_W,
	parameter int NUM_SLOTS = `ACEM_NUM_SLOTS,
	parameter int DEPTH = `ACEM_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [ID_W-1:0] arid,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [1:0] arburst,
	input wire logic [7:0] arlen,
	input wire logic [2:0] arsize,
	input wire logic [3:0] arcache,
	input wire logic [2:0] arprot,
	input wire logic [LOCK_W-1:0] arlock,
	input wire logic [3:0] arqos,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic rlast,
	input wire logic [ID_W-1:0] rid,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [ID_W-1:0] awid,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [1:0] awburst,
	input wire logic [7:0] awlen,
	input wire logic [2:0] awsize,
	input wire logic [3:0] awcache,
	input wire logic [2:0] awprot,
	input wire logic [LOCK_W-1:0] awlock,
	input wire logic [3:0] awqos,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic wlast,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [DATA_W/8-1:0] wstrb,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [ID_W-1:0] bid,
	input wire logic [1:0] bresp,
	output acem_pkg::acem_addr_ev_e ar_event_reg,
	output acem_pkg::acem_data_ev_e r_event_reg,
	output acem_pkg::acem_addr_ev_e aw_event_reg,
	output acem_pkg::acem_data_ev_e w_event_reg,
	output acem_pkg::acem_resp_ev_e b_event_reg,
	output logic ar_rec_valid_reg,
	output logic ar_rec_ready_reg,
	output logic [ID_W-1:0] ar_rec_id_reg,
	output logic [ADDR_W-1:0] ar_rec_addr_reg,
	output logic [1:0] ar_rec_burst_reg,
	output logic [7:0] ar_rec_len_reg,
	output logic [2:0] ar_rec_size_reg,
	output logic [3:0] ar_rec_cache_reg,
	output logic [2:0] ar_rec_prot_reg,
	output logic [LOCK_W-1:0] ar_rec_lock_reg,
	output logic [3:0] ar_rec_qos_reg,
	output logic r_rec_valid_reg,
	output logic r_rec_ready_reg,
	output logic r_rec_last_reg,
	output logic [ID_W-1:0] r_rec_id_reg,
	output logic [DATA_W-1:0] r_rec_data_reg,
	output logic [1:0] r_rec_resp_reg,
	output logic aw_rec_valid_reg,
	output logic aw_rec_ready_reg,
	output logic [ID_W-1:0] aw_rec_id_reg,
	output logic [ADDR_W-1:0] aw_rec_addr_reg,
	output logic [1:0] aw_rec_burst_reg,
	output logic [7:0] aw_rec_len_reg,
	output logic [2:0] aw_rec_size_reg,
	output logic [3:0] aw_rec_cache_reg,
	output logic [2:0] aw_rec_prot_reg,
	output logic [LOCK_W-1:0] aw_rec_lock_reg,
	output logic [3:0] aw_rec_qos_reg,
	output logic w_rec_valid_reg,
	output logic w_rec_ready_reg,
	output logic w_rec_last_reg,
	output logic [DATA_W-1:0] w_rec_data_reg,
	output logic [DATA_W/8-1:0] w_rec_strb_reg,
	output logic b_rec_valid_reg,
	output logic b_rec_ready_reg,
	output logic [ID_W-1:0] b_rec_id_reg,
	output logic [1:0] b_rec_resp_reg,
	output logic [15:0] read_cmd_outstanding_count,
	output logic [15:0] write_cmd_outstanding_count,
	output logic rd_done_valid_reg,
	output logic [ID_W-1:0] rd_done_id_reg,
	output logic [ADDR_W-1:0] rd_done_addr_reg,
	output logic [TIME_W-1:0] rd_done_start_reg,
	output logic [TIME_W-1:0] rd_done_end_reg,
	output logic [TIME_W-1:0] rd_done_dur_reg,
	output logic wr_done_valid_reg,
	output logic [ID_W-1:0] wr_done_id_reg,
	output logic [ADDR_W-1:0] wr_done_addr_reg,
	output logic [TIME_W-1:0] wr_done_start_reg,
	output logic [TIME_W-1:0] wr_done_end_reg,
	output logic [TIME_W-1:0] wr_done_dur_reg,
	output logic rd_overflow_reg,
	output logic wr_overflow_reg
);
	import acem_pkg::*;

	// ==========================================================
	// Time base and command state
	// ==========================================================
	// Every input is only ever read here; the monitor drives nothing
	// back onto the watched bus
	logic [TIME_W-1:0] now_reg;
	acem_addr_ev_e ar_state_reg, ar_state_next;
	acem_addr_ev_e aw_state_reg, aw_state_next;
	logic [TIME_W-1:0] ar_start_reg, aw_start_reg;
	logic [TIME_W-1:0] ar_open_time, aw_open_time;
	logic w_both_prev_reg;
	logic ar_hs, aw_hs, r_hs, w_hs, b_hs;

	assign ar_hs = arvalid && arready;
	assign aw_hs = awvalid && awready;
	assign r_hs = rvalid && rready;
	assign w_hs = wvalid && wready;
	assign b_hs = bvalid && bready;

	// Free-running cycle stamp; wraps, so durations stay modular
	always_ff @(posedge clk) begin
		if (!rst_n)
			now_reg <= '0;
		else
			now_reg <= now_reg + TIME_W'(1);
	end

	// Read address command: open on valid, close on handshake
	always_comb begin
		ar_state_next = ar_state_reg;
		case (ar_state_reg)
			ACEM_AEV_IDLE: begin
				if (arvalid && !arready)
					ar_state_next = ACEM_AEV_CMD;
			end
			ACEM_AEV_CMD: begin
				if (ar_hs)
					ar_state_next = ACEM_AEV_IDLE;
			end
			default: ar_state_next = ACEM_AEV_IDLE;
		endcase
	end

	// Write address command: same shape as the read side
	always_comb begin
		aw_state_next = aw_state_reg;
		case (aw_state_reg)
			ACEM_AEV_IDLE: begin
				if (awvalid && !awready)
					aw_state_next = ACEM_AEV_CMD;
			end
			ACEM_AEV_CMD: begin
				if (aw_hs)
					aw_state_next = ACEM_AEV_IDLE;
			end
			default: aw_state_next = ACEM_AEV_IDLE;
		endcase
	end

	// Start stamp is the first valid cycle, not the handshake
	assign ar_open_time = (ar_state_reg == ACEM_AEV_CMD) ?
		ar_start_reg : now_reg;
	assign aw_open_time = (aw_state_reg == ACEM_AEV_CMD) ?
		aw_start_reg : now_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ar_state_reg <= ACEM_AEV_IDLE;
			aw_state_reg <= ACEM_AEV_IDLE;
			ar_start_reg <= '0;
			aw_start_reg <= '0;
		end else begin
			ar_state_reg <= ar_state_next;
			aw_state_reg <= aw_state_next;
			if (ar_state_reg == ACEM_AEV_IDLE && arvalid)
				ar_start_reg <= now_reg;
			if (aw_state_reg == ACEM_AEV_IDLE && awvalid)
				aw_start_reg <= now_reg;
		end
	end

	// ==========================================================
	// Channel events, one cycle after the sampled edge
	// ==========================================================
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ar_event_reg <= ACEM_AEV_IDLE;
			aw_event_reg <= ACEM_AEV_IDLE;
			r_event_reg <= ACEM_DEV_IDLE;
			w_event_reg <= ACEM_DEV_IDLE;
			b_event_reg <= ACEM_BEV_IDLE;
			w_both_prev_reg <= 1'b0;
		end else begin
			// Command shows from first valid through handshake
			if (arvalid)
				ar_event_reg <= ACEM_AEV_CMD;
			else
				ar_event_reg <= ACEM_AEV_IDLE;
			if (awvalid)
				aw_event_reg <= ACEM_AEV_CMD;
			else
				aw_event_reg <= ACEM_AEV_IDLE;
			if (r_hs && rlast)
				r_event_reg <= ACEM_DEV_LAST;
			else if (r_hs)
				r_event_reg <= ACEM_DEV_BEAT;
			else
				r_event_reg <= ACEM_DEV_IDLE;
			// Streamed non-last write beats count once per stream
			if (w_hs && wlast)
				w_event_reg <= ACEM_DEV_LAST;
			else if (w_hs && !w_both_prev_reg)
				w_event_reg <= ACEM_DEV_BEAT;
			else
				w_event_reg <= ACEM_DEV_IDLE;
			w_both_prev_reg <= w_hs;
			if (b_hs)
				b_event_reg <= ACEM_BEV_RESP;
			else
				b_event_reg <= ACEM_BEV_IDLE;
		end
	end

	// ==========================================================
	// Signal group records, aligned with the event outputs
	// ==========================================================
	// Read address group
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ar_rec_valid_reg <= 1'b0;
			ar_rec_ready_reg <= 1'b0;
		end else begin
			ar_rec_valid_reg <= arvalid;
			ar_rec_ready_reg <= arready;
		end
	end

	// Payload fields need no reset; they are qualified by valid
	always_ff @(posedge clk) begin
		ar_rec_id_reg <= arid;
		ar_rec_addr_reg <= araddr;
		ar_rec_burst_reg <= arburst;
		ar_rec_len_reg <= arlen;
		ar_rec_size_reg <= arsize;
		ar_rec_cache_reg <= arcache;
		ar_rec_prot_reg <= arprot;
		ar_rec_lock_reg <= arlock;
		ar_rec_qos_reg <= arqos;
		r_rec_id_reg <= rid;
		r_rec_data_reg <= rdata;
		r_rec_resp_reg <= rresp;
		aw_rec_id_reg <= awid;
		aw_rec_addr_reg <= awaddr;
		aw_rec_burst_reg <= awburst;
		aw_rec_len_reg <= awlen;
		aw_rec_size_reg <= awsize;
		aw_rec_cache_reg <= awcache;
		aw_rec_prot_reg <= awprot;
		aw_rec_lock_reg <= awlock;
		aw_rec_qos_reg <= awqos;
		w_rec_data_reg <= wdata;
		w_rec_strb_reg <= wstrb;
		b_rec_id_reg <= bid;
		b_rec_resp_reg <= bresp;
	end

	// Control bits of the remaining groups
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r_rec_valid_reg <= 1'b0;
			r_rec_ready_reg <= 1'b0;
			r_rec_last_reg <= 1'b0;
			aw_rec_valid_reg <= 1'b0;
			aw_rec_ready_reg <= 1'b0;
			w_rec_valid_reg <= 1'b0;
			w_rec_ready_reg <= 1'b0;
			w_rec_last_reg <= 1'b0;
			b_rec_valid_reg <= 1'b0;
			b_rec_ready_reg <= 1'b0;
		end else begin
			r_rec_valid_reg <= rvalid;
			r_rec_ready_reg <= rready;
			r_rec_last_reg <= rlast;
			aw_rec_valid_reg <= awvalid;
			aw_rec_ready_reg <= awready;
			w_rec_valid_reg <= wvalid;
			w_rec_ready_reg <= wready;
			w_rec_last_reg <= wlast;
			b_rec_valid_reg <= bvalid;
			b_rec_ready_reg <= bready;
		end
	end

	// ==========================================================
	// Transaction pairing
	// ==========================================================
	// Read: opens at command handshake with first-valid stamp,
	// closes on the last beat carrying the same ID
	acem_txn_tracker #(
		.ID_W(ID_W),
		.ADDR_W(ADDR_W),
		.TIME_W(TIME_W),
		.NUM_SLOTS(NUM_SLOTS),
		.DEPTH(DEPTH)
	) u_rd_track (
		.clk(clk),
		.rst_n(rst_n),
		.open_valid(ar_hs),
		.open_id(arid),
		.open_addr(araddr),
		.open_time(ar_open_time),
		.close_valid(r_hs && rlast),
		.close_id(rid),
		.close_time(now_reg),
		.done_valid_reg(rd_done_valid_reg),
		.done_id_reg(rd_done_id_reg),
		.done_addr_reg(rd_done_addr_reg),
		.done_start_reg(rd_done_start_reg),
		.done_end_reg(rd_done_end_reg),
		.done_dur_reg(rd_done_dur_reg),
		.outstanding_reg(read_cmd_outstanding_count),
		.overflow_reg(rd_overflow_reg)
	);

	// Write: closes on the response with matching ID
	acem_txn_tracker #(
		.ID_W(ID_W),
		.ADDR_W(ADDR_W),
		.TIME_W(TIME_W),
		.NUM_SLOTS(NUM_SLOTS),
		.DEPTH(DEPTH)
	) u_wr_track (
		.clk(clk),
		.rst_n(rst_n),
		.open_valid(aw_hs),
		.open_id(awid),
		.open_addr(awaddr),
		.open_time(aw_open_time),
		.close_valid(b_hs),
		.close_id(bid),
		.close_time(now_reg),
		.done_valid_reg(wr_done_valid_reg),
		.done_id_reg(wr_done_id_reg),
		.done_addr_reg(wr_done_addr_reg),
		.done_start_reg(wr_done_start_reg),
		.done_end_reg(wr_done_end_reg),
		.done_dur_reg(wr_done_dur_reg),
		.outstanding_reg(write_cmd_outstanding_count),
		.overflow_reg(wr_overflow_reg)
	);
endmodule // acem_monitor

// *** verification/acem_axi_pair.sv ***
// Behavioural master and slave pair that drives the probed bus
`timescale 1ns/1ps
module acem_axi_pair (
	output logic arvalid, arready, rvalid, rready, rlast,
	output logic awvalid, awready, wvalid, wready, wlast, bvalid, bready,
	output logic [3:0] arid, rid, awid, bid, arcache, awcache, arqos, awqos,
	output logic [31:0] araddr, awaddr, rdata, wdata,
	output logic [1:0] arburst, awburst, rresp, bresp,
	output logic [7:0] arlen, awlen,
	output logic [2:0] arsize, awsize, arprot, awprot,
	output logic [0:0] arlock, awlock,
	output logic [3:0] wstrb
);
	// Fixed command attributes: incr burst, four beats, word size
	localparam logic [24:0] CMD = {2'h1, 8'h03, 3'h2, 4'h3, 3'h1, 1'h0, 4'h2};
	// ==================================================================
	// Bus driving
	// Payloads of an idle channel carry the inverse of the real value, so a
	// monitor that records stale payload cannot pass by luck
	task automatic drive(input logic [11:0] c, input logic [3:0] id,
		input logic [31:0] a);
		{arvalid, arready, rvalid, rready, rlast} = c[11:7];
		{awvalid, awready, wvalid, wready, wlast, bvalid, bready} = c[6:0];
		{arid, araddr} = c[11] ? {id, a} : ~{id, a};
		{arburst, arlen, arsize, arcache, arprot, arlock, arqos} =
			c[11] ? CMD : ~CMD;
		{rid, rdata, rresp} = c[9] ? {id, a, 2'h0} : ~{id, a, 2'h0};
		{awid, awaddr} = c[6] ? {id, a} : ~{id, a};
		{awburst, awlen, awsize, awcache, awprot, awlock, awqos} =
			c[6] ? CMD : ~CMD;
		{wdata, wstrb} = c[4] ? {a, 4'hf} : ~{a, 4'hf};
		{bid, bresp} = c[1] ? {id, 2'h0} : ~{id, 2'h0};
	endtask
	// Idle bus from time zero
	initial begin
		drive(12'h000, 4'h0, 32'h0);
	end
endmodule // acem_axi_pair

// *** verification/acem_monitor_sva.sv ***
// Concurrent checks on the channel event outputs of the monitor
`timescale 1ns/1ps
module acem_monitor_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic arvalid, arready, rvalid, rready, rlast,
	input wire logic awvalid, awready, wvalid, wready, wlast, bvalid, bready,
	input wire acem_pkg::acem_addr_ev_e ar_event_reg, aw_event_reg,
	input wire acem_pkg::acem_data_ev_e r_event_reg, w_event_reg,
	input wire acem_pkg::acem_resp_ev_e b_event_reg,
	input wire logic rd_done_valid_reg, wr_done_valid_reg,
	input wire logic rd_overflow_reg, wr_overflow_reg
);
	import acem_pkg::*;
	// ==================================================================
	// Event coding, one cycle after the sampled valid or handshake
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	ar_open_a: assert property (arvalid |=>
		ar_event_reg == ACEM_AEV_CMD)
		else $error("read command not reported");
	ar_idle_a: assert property (!arvalid |=>
		ar_event_reg == ACEM_AEV_IDLE)
		else $error("read address channel not idle");
	r_beat_a: assert property (rvalid && rready && !rlast |=>
		r_event_reg == ACEM_DEV_BEAT)
		else $error("read beat not reported");
	r_last_a: assert property (rvalid && rready && rlast |=>
		r_event_reg == ACEM_DEV_LAST)
		else $error("last read beat not reported");
	r_idle_a: assert property (!(rvalid && rready) |=>
		r_event_reg == ACEM_DEV_IDLE)
		else $error("read data channel not idle");
	aw_open_a: assert property (awvalid |=>
		aw_event_reg == ACEM_AEV_CMD)
		else $error("write command not reported");
	aw_idle_a: assert property (!awvalid |=>
		aw_event_reg == ACEM_AEV_IDLE)
		else $error("write address channel not idle");
	w_beat_a: assert property (wvalid && wready && !wlast &&
		!($past(wvalid) && $past(wready)) |=> w_event_reg == ACEM_DEV_BEAT)
		else $error("write beat not reported");
	w_last_a: assert property (wvalid && wready && wlast |=>
		w_event_reg == ACEM_DEV_LAST)
		else $error("last write beat not reported");
	w_idle_a: assert property (!(wvalid && wready) |=>
		w_event_reg == ACEM_DEV_IDLE)
		else $error("write data channel not idle");
	b_resp_a: assert property (bvalid && bready |=>
		b_event_reg == ACEM_BEV_RESP)
		else $error("write response not reported");
	b_idle_a: assert property (!(bvalid && bready) |=>
		b_event_reg == ACEM_BEV_IDLE)
		else $error("response channel not idle");
	// ==================================================================
	// Completion and overflow
	rd_done_a: assert property (rd_done_valid_reg |-> $past(rvalid) &&
		$past(rready) && $past(rlast))
		else $error("read completion without last beat");
	wr_done_a: assert property (wr_done_valid_reg |->
		$past(bvalid) && $past(bready))
		else $error("write completion without response");
	ovf_hold_a: assert property ($rose(rd_overflow_reg) |=>
		rd_overflow_reg [*8])
		else $error("read overflow not sticky");
	wovf_hold_a: assert property (wr_overflow_reg |=> wr_overflow_reg)
		else $error("write overflow not sticky");
endmodule // acem_monitor_sva
bind acem_monitor acem_monitor_sva i_chk (.*);

// *** verification/test_axi_channel_event_monitor.sv ***
// Self-checking bench for the AXI channel event monitor
`timescale 1ns/1ps
`include "acem_consts.svh"
module test_axi_channel_event_monitor;
	import acem_pkg::*;
	localparam logic [31:0] ADDR = 32'h0000_4a10;
	// Row: bus controls, then expected codes ar, r, aw, w, b (0 idle)
	typedef struct packed {
		logic [11:0] c;
		logic [9:0] e;
	} acem_row_s;
	// ==================================================================
	// Signals, dut and partner
	logic clk, rst_n;
	logic arvalid, arready, rvalid, rready, rlast;
	logic awvalid, awready, wvalid, wready, wlast, bvalid, bready;
	logic [3:0] arid, rid, awid, bid, arcache, awcache, arqos, awqos, wstrb;
	logic [31:0] araddr, awaddr, rdata, wdata;
	logic [1:0] arburst, awburst, rresp, bresp;
	logic [7:0] arlen, awlen;
	logic [2:0] arsize, awsize, arprot, awprot;
	logic [0:0] arlock, awlock, ar_rec_lock_reg, aw_rec_lock_reg;
	acem_addr_ev_e ar_event_reg, aw_event_reg;
	acem_data_ev_e r_event_reg, w_event_reg;
	acem_resp_ev_e b_event_reg;
	logic ar_rec_valid_reg, ar_rec_ready_reg, r_rec_valid_reg, r_rec_ready_reg;
	logic r_rec_last_reg, aw_rec_valid_reg, aw_rec_ready_reg, w_rec_valid_reg;
	logic w_rec_ready_reg, w_rec_last_reg, b_rec_valid_reg, b_rec_ready_reg;
	logic rd_done_valid_reg, wr_done_valid_reg, rd_overflow_reg, wr_overflow_reg;
	logic [3:0] ar_rec_id_reg, r_rec_id_reg, aw_rec_id_reg, b_rec_id_reg;
	logic [3:0] ar_rec_cache_reg, aw_rec_cache_reg, ar_rec_qos_reg;
	logic [3:0] aw_rec_qos_reg, w_rec_strb_reg, rd_done_id_reg, wr_done_id_reg;
	logic [31:0] ar_rec_addr_reg, aw_rec_addr_reg, r_rec_data_reg, w_rec_data_reg;
	logic [31:0] rd_done_addr_reg, rd_done_start_reg, rd_done_end_reg;
	logic [31:0] rd_done_dur_reg, wr_done_addr_reg, wr_done_start_reg;
	logic [31:0] wr_done_end_reg, wr_done_dur_reg;
	logic [1:0] ar_rec_burst_reg, aw_rec_burst_reg;
	logic [1:0] r_rec_resp_reg, b_rec_resp_reg;
	logic [7:0] ar_rec_len_reg, aw_rec_len_reg;
	logic [2:0] ar_rec_size_reg, aw_rec_size_reg;
	logic [2:0] ar_rec_prot_reg, aw_rec_prot_reg;
	logic [15:0] read_cmd_outstanding_count, write_cmd_outstanding_count;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;
	acem_row_s rows [16] = '{'{12'h800, 10'h100}, '{12'hc00, 10'h100},
		'{12'h000, 10'h000}, '{12'h300, 10'h040}, '{12'h380, 10'h080},
		'{12'h000, 10'h000}, '{12'h040, 10'h010}, '{12'h060, 10'h010},
		'{12'h018, 10'h004}, '{12'h018, 10'h000}, '{12'h01c, 10'h008},
		'{12'h010, 10'h000}, '{12'h018, 10'h004}, '{12'h002, 10'h000},
		'{12'h003, 10'h001}, '{12'h000, 10'h000}};
	acem_monitor i_dut (.*);
	acem_axi_pair i_pair (.*);
	// ==================================================================
	// Clock, time limit and shared tasks
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// A hang shows up as a mismatch rather than a silent stall
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	// Drive one cycle at the falling edge, return after the sampling edge
	task automatic cyc(input logic [11:0] c, input logic [3:0] id);
		i_pair.drive(c, id, ADDR);
		@(negedge clk);
	endtask
	function automatic logic [31:0] aev(input logic [1:0] k);
		return k[0] ? ACEM_AEV_CMD : ACEM_AEV_IDLE;
	endfunction
	function automatic logic [31:0] dev(input logic [1:0] k);
		return k[1] ? ACEM_DEV_LAST : (k[0] ? ACEM_DEV_BEAT : ACEM_DEV_IDLE);
	endfunction
	task automatic chk_ev(input logic [9:0] e);
		chk("ar_event", aev(e[9:8]), ar_event_reg);
		chk("r_event", dev(e[7:6]), r_event_reg);
		chk("aw_event", aev(e[5:4]), aw_event_reg);
		chk("w_event", dev(e[3:2]), w_event_reg);
		chk("b_event", e[0] ? ACEM_BEV_RESP : ACEM_BEV_IDLE, b_event_reg);
	endtask
	task automatic results();
		$display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ==================================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		// One read of id 1 from cycle 0 to 4, one write from cycle 6 to 14
		for (int i = 0; i < 16; i++) begin
			cyc(rows[i].c, 4'h1);
			chk_ev(rows[i].e);
			if (i == 1) begin
				chk("ar_rec_addr", ADDR, ar_rec_addr_reg);
				chk("ar_rec_len", 8'h03, ar_rec_len_reg);
			end
			if (i == 3) chk("rd_count", 1, read_cmd_outstanding_count);
			if (i == 4) begin
				chk("rd_done_valid", 1, rd_done_valid_reg);
				chk("rd_done_dur", 4, rd_done_dur_reg);
				chk("rd_done_span", 4, rd_done_end_reg - rd_done_start_reg);
				chk("rd_done_addr", ADDR, rd_done_addr_reg);
				chk("r_rec_data", ADDR, r_rec_data_reg);
			end
			if (i == 7) chk("aw_rec_addr", ADDR, aw_rec_addr_reg);
			if (i == 8) chk("w_rec_strb", 4'hf, w_rec_strb_reg);
			if (i == 10) chk("wr_count", 1, write_cmd_outstanding_count);
			if (i == 14) begin
				chk("wr_done_dur", 8, wr_done_dur_reg);
				chk("wr_done_id", 1, wr_done_id_reg);
				chk("wr_done_addr", ADDR, wr_done_addr_reg);
			end
		end
		// Last beat with a foreign id must not close the open read
		cyc(12'hc00, 4'h2);
		cyc(12'h000, 4'h2);
		cyc(12'h380, 4'h3);
		chk("rd_done_valid", 0, rd_done_valid_reg);
		cyc(12'h380, 4'h2);
		chk("rd_done_id", 2, rd_done_id_reg);
		// One more back-to-back read of one id than a slot can hold
		repeat (`ACEM_DEPTH + 1) cyc(12'hc00, 4'h5);
		cyc(12'h000, 4'h5);
		cyc(12'h000, 4'h5);
		chk("rd_overflow", 1, rd_overflow_reg);
		chk("wr_overflow", 0, wr_overflow_reg);
		// One more write id than there are slots to track them
		for (int k = 0; k <= `ACEM_NUM_SLOTS; k++) begin
			cyc(12'h060, 4'(k));
		end
		chk("wr_overflow", 1, wr_overflow_reg);
		// Reset in mid command clears events, counts and overflow
		cyc(12'h800, 4'h6);
		rst_n = 1'b0;
		cyc(12'h800, 4'h6);
		cyc(12'h800, 4'h6);
		chk("ar_event", ACEM_AEV_IDLE, ar_event_reg);
		chk("rd_count", 0, read_cmd_outstanding_count);
		chk("rd_overflow", 0, rd_overflow_reg);
		chk("wr_overflow_clr", 0, wr_overflow_reg);
		rst_n = 1'b1;
		cyc(12'hc00, 4'h6);
		chk("ar_event", ACEM_AEV_CMD, ar_event_reg);
		cyc(12'h000, 4'h6);
		results();
	end
endmodule // test_axi_channel_event_monitor
